// ---- core/dcr_pkg.sv ----
// ============================================================
// Shared constants and types for the result status block
package dcr_pkg;

    // ============================================================
    // Byte geometry
    localparam int ST_WIDTH        = 8;           // Width of each result byte
    localparam logic [7:0] STATUS_RESET = 8'h00;  // Value of both bytes after reset

    // ============================================================
    // Result byte A field positions
    localparam int ST0_CODE_HI = 7;  // Termination code, upper bit
    localparam int ST0_CODE_LO = 6;  // Termination code, lower bit
    localparam int ST0_SEEK    = 5;  // Seek finished
    localparam int ST0_EQUIP   = 4;  // Drive fault or failed recalibrate
    localparam int ST0_NREADY  = 3;  // Drive not ready at issue
    localparam int ST0_HEAD    = 2;  // Head at interrupt
    localparam int ST0_UNIT_HI = 1;  // Drive number, upper bit
    localparam int ST0_UNIT_LO = 0;  // Drive number, lower bit

    // ============================================================
    // Result byte B field positions
    localparam int ST1_END_CYL = 7;  // Access past the last sector
    localparam int ST1_RSVD_HI = 6;  // Always zero
    localparam int ST1_CRC     = 5;  // CRC failure, ID or data field
    localparam int ST1_OVERRUN = 4;  // Host too slow
    localparam int ST1_RSVD_LO = 3;  // Always zero
    localparam int ST1_NODATA  = 2;  // Sector not found
    localparam int ST1_NOWRITE = 1;  // Write protected
    localparam int ST1_IDMARK  = 0;  // ID address mark missing

    // ============================================================
    // Termination codes
    localparam logic [1:0] TERM_NORMAL  = 2'h0;  // Completed properly
    localparam logic [1:0] TERM_FAILED  = 2'h1;  // Started, not completed
    localparam logic [1:0] TERM_INVALID = 2'h2;  // Never started
    localparam logic [1:0] TERM_RDY_CHG = 2'h3;  // Ready line moved

    // ============================================================
    // Counts and selects
    localparam int RECAL_STEP_LIMIT = 77;    // Steps before giving up on track zero
    localparam logic RES_SEL_A      = 1'b0;  // Read result byte A
    localparam logic RES_SEL_B      = 1'b1;  // Read result byte B

    // ============================================================
    // Command kinds
    typedef enum logic [3:0] {
        CMD_READ_DATA  = 4'h0,
        CMD_READ_DEL   = 4'h1,
        CMD_WRITE_DATA = 4'h2,
        CMD_WRITE_DEL  = 4'h3,
        CMD_READ_CYL   = 4'h4,
        CMD_READ_ID    = 4'h5,
        CMD_FORMAT     = 4'h6,
        CMD_SCAN       = 4'h7,
        CMD_RECAL      = 4'h8,
        CMD_SEEK       = 4'h9,
        CMD_SENSE_INT  = 4'hA,
        CMD_SPECIFY    = 4'hB,
        CMD_SENSE_DRV  = 4'hC
    } dcr_cmd_t;

    // Block phases
    typedef enum logic [1:0] {
        PH_IDLE   = 2'b00,
        PH_EXEC   = 2'b01,
        PH_RESULT = 2'b10
    } dcr_phase_t;

    // ============================================================
    // Command classes
    // Commands that move data to or from the medium
    function automatic logic is_rw(input dcr_cmd_t k);
        is_rw = (k <= CMD_SCAN);
    endfunction

    // Commands that write the medium
    function automatic logic is_write(input dcr_cmd_t k);
        is_write = (k == CMD_WRITE_DATA) || (k == CMD_WRITE_DEL) || (k == CMD_FORMAT);
    endfunction

endpackage

// ---- core/dcr_recal_if.sv ----
`timescale 1ns/1ps
// ============================================================
// Link between the status core and the recalibrate watcher
interface dcr_recal_if;
    logic active;  // Recalibrate in execution
    logic step;    // One step pulse issued
    logic track0;  // Track zero seen from drive
    logic fail;    // Step limit reached without track zero

    modport ctrl  (output active, output step, output track0, input fail);
    modport watch (input active, input step, input track0, output fail);
endinterface

// ---- core/dcr_recal_watch.sv ----
`timescale 1ns/1ps
// ============================================================
// Counts recalibrate steps and flags a missing track zero
module dcr_recal_watch
    import dcr_pkg::*;
#(
    parameter int STEP_LIMIT = RECAL_STEP_LIMIT,  // Steps allowed
    parameter int CNT_W      = 7                  // Counter width
) (
    // Clock and reset
    input wire logic     ref_clk,
    input wire logic     rst,
    // Link to status core
    dcr_recal_if.watch   rc
);

    // Refuse limits the counter cannot hold
    if (STEP_LIMIT < 1 || STEP_LIMIT >= (1 << CNT_W)) begin : g_bad_limit
        $error("STEP_LIMIT does not fit the counter");
    end

    localparam logic [CNT_W-1:0] LIMIT = CNT_W'(STEP_LIMIT);  // Limit at counter width

    logic [CNT_W-1:0] cnt_q;  // Steps issued so far
    logic [CNT_W-1:0] cnt_d;  // Next count
    logic             at_limit;

    // Count only while recalibrating, saturate at the limit
    assign at_limit = (cnt_q == LIMIT);
    assign cnt_d    = !rc.active ? '0 :
                      (rc.step && !at_limit) ? cnt_q + 1'b1 : cnt_q;
    // Limit reached and track zero still absent
    assign rc.fail  = rc.active && at_limit && !rc.track0;

    // Step counter
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    // Each step below the limit advances the count by one
    a_recal_step_count: assert property (@(posedge ref_clk) disable iff (rst)
        rc.active && rc.step && !at_limit ##1 rc.active |-> cnt_q == $past(cnt_q) + 1'b1)
        else $error("Recalibrate step not counted");

endmodule

// ---- core/disk_ctrl_result_status.sv ----
`timescale 1ns/1ps
// ============================================================
module disk_ctrl_result_status
    import dcr_pkg::*;
(
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Command issue
    input  wire logic             cmd_start,
    input  wire dcr_cmd_t         cmd_kind,
    input  wire logic             cmd_invalid,
    input  wire logic             cmd_head,
    input  wire logic [1:0]       cmd_unit,
    // Drive status lines
    input  wire logic             drv_ready,
    input  wire logic             drv_fault,
    input  wire logic             drv_track0,
    input  wire logic             drv_two_side,
    input  wire logic             drv_wprot,
    input  wire logic             drv_step,
    // Execution events
    input  wire logic             ev_done,
    input  wire logic             ev_seek_done,
    input  wire logic             ev_end_cyl,
    input  wire logic             ev_crc_id,
    input  wire logic             ev_crc_data,
    input  wire logic             ev_overrun,
    input  wire logic             ev_sector_miss,
    input  wire logic             ev_id_bad,
    input  wire logic             ev_start_miss,
    input  wire logic             ev_id_mark_miss,
    input  wire logic             ev_data_mark_miss,
    // Result read port
    input  wire logic             res_rd,
    input  wire logic             res_sel,
    output logic [ST_WIDTH-1:0]   res_data,
    output logic                  result_phase,
    output logic                  data_mark_missing
);

    // ============================================================
    // State and captured command
    dcr_phase_t  phase_q;       // Current phase
    dcr_phase_t  phase_d;       // Next phase
    dcr_cmd_t    kind_q;        // Command in progress
    logic        head_q;        // Head of the command
    logic [1:0]  unit_q;        // Drive unit of the command
    logic        rdy_ref_q;     // Ready level at issue

    // Sticky flags
    logic        seek_q;
    logic        equip_q;
    logic        nready_q;
    logic        endcyl_q;
    logic        crc_q;
    logic        ovr_q;
    logic        nodata_q;
    logic        nowrite_q;
    logic        idmark_q;
    logic        dmark_q;
    logic [1:0]  code_q;        // Termination code
    logic [1:0]  code_d;
    logic [ST_WIDTH-1:0] res_data_q;  // Last byte read

    // ============================================================
    // Decode of phase and command
    logic        exec;          // Execution in progress
    logic        start_ok;      // New command taken
    logic        issue_nr;      // Read/write on unready drive or missing side
    logic        rdy_change;    // Ready moved during execution
    logic        recal_fail;    // Recalibrate gave up
    logic        finish;        // Execution ends this cycle
    logic        is_locate;     // Commands that look for a given sector

    assign exec       = (phase_q == PH_EXEC);
    assign start_ok   = cmd_start && !exec;  // Ignored while executing
    assign issue_nr   = start_ok && !cmd_invalid && is_rw(cmd_kind) &&
                        (!drv_ready || (cmd_head && !drv_two_side));
    assign rdy_change = exec && (drv_ready != rdy_ref_q);
    assign finish     = exec && (ev_done || rdy_change || recal_fail);
    assign is_locate  = (kind_q == CMD_READ_DATA) || (kind_q == CMD_WRITE_DEL) ||
                        (kind_q == CMD_SCAN);

    // ============================================================
    // Recalibrate watcher
    dcr_recal_if rc ();

    assign rc.active = exec && (kind_q == CMD_RECAL);
    assign rc.step   = drv_step;
    assign rc.track0 = drv_track0;
    assign recal_fail = rc.fail;

    dcr_recal_watch #(
        .STEP_LIMIT (RECAL_STEP_LIMIT),
        .CNT_W      (7)
    ) u_recal (
        .ref_clk (ref_clk),
        .rst     (rst),
        .rc      (rc)
    );

    // ============================================================
    // Flag set terms, active only during execution
    logic set_seek;
    logic set_equip;
    logic set_endcyl;
    logic set_crc;
    logic set_ovr;
    logic set_nodata;
    logic set_nowrite;
    logic set_idmark;
    logic set_dmark;

    assign set_seek    = exec && ev_seek_done && (kind_q == CMD_SEEK);
    assign set_equip   = exec && (drv_fault || recal_fail);
    assign set_endcyl  = exec && ev_end_cyl;
    assign set_crc     = exec && (ev_crc_id || ev_crc_data);
    assign set_ovr     = exec && ev_overrun;
    assign set_nodata  = exec && ((ev_sector_miss && is_locate) ||
                         (ev_id_bad && (kind_q == CMD_READ_ID)) ||
                         (ev_start_miss && (kind_q == CMD_READ_CYL)));
    assign set_nowrite = exec && drv_wprot && is_write(kind_q);
    assign set_idmark  = exec && ev_id_mark_miss;
    assign set_dmark   = exec && (ev_id_mark_miss || ev_data_mark_miss);

    // Set wins over the clear of a new command
    function automatic logic upd(input logic q, input logic set, input logic clr);
        upd = set || (q && !clr);
    endfunction

    // Any error flag that will stand after this cycle
    logic err_next;
    assign err_next = upd(equip_q, set_equip, 1'b0) || nready_q ||
                      upd(endcyl_q, set_endcyl, 1'b0) || upd(crc_q, set_crc, 1'b0) ||
                      upd(ovr_q, set_ovr, 1'b0) || upd(nodata_q, set_nodata, 1'b0) ||
                      upd(nowrite_q, set_nowrite, 1'b0) ||
                      upd(idmark_q, set_idmark, 1'b0) || upd(dmark_q, set_dmark, 1'b0);

    // ============================================================
    // Termination code and phase selection
    always_comb begin
        code_d  = code_q;
        phase_d = phase_q;
        case (phase_q)
            // Waiting for a command
            PH_IDLE, PH_RESULT: begin
                if (start_ok && cmd_invalid) begin
                    code_d  = TERM_INVALID;
                    phase_d = PH_RESULT;
                end else if (issue_nr) begin
                    code_d  = TERM_FAILED;
                    phase_d = PH_RESULT;
                end else if (start_ok) begin
                    code_d  = TERM_NORMAL;
                    phase_d = PH_EXEC;
                end
            end
            // Executing until done, ready change or recal failure
            PH_EXEC: begin
                if (finish) begin
                    phase_d = PH_RESULT;
                    if (rdy_change) begin
                        code_d = TERM_RDY_CHG;
                    end else if (err_next) begin
                        code_d = TERM_FAILED;
                    end else begin
                        code_d = TERM_NORMAL;
                    end
                end
            end
            // Unused code returns to idle
            default: begin
                phase_d = PH_IDLE;
            end
        endcase
    end

    // ============================================================
    // Result bytes assembled from flags
    logic [ST_WIDTH-1:0] st_a;
    logic [ST_WIDTH-1:0] st_b;

    always_comb begin
        st_a              = STATUS_RESET;
        st_a[ST0_CODE_HI] = code_q[1];
        st_a[ST0_CODE_LO] = code_q[0];
        st_a[ST0_SEEK]    = seek_q;
        st_a[ST0_EQUIP]   = equip_q;
        st_a[ST0_NREADY]  = nready_q;
        st_a[ST0_HEAD]    = head_q;
        st_a[ST0_UNIT_HI] = unit_q[1];
        st_a[ST0_UNIT_LO] = unit_q[0];
    end

    always_comb begin
        st_b              = STATUS_RESET;
        st_b[ST1_END_CYL] = endcyl_q;
        st_b[ST1_CRC]     = crc_q;
        st_b[ST1_OVERRUN] = ovr_q;
        st_b[ST1_NODATA]  = nodata_q;
        st_b[ST1_NOWRITE] = nowrite_q;
        st_b[ST1_IDMARK]  = idmark_q;
    end

    // ============================================================
    // Phase and captured command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            phase_q   <= PH_IDLE;
            kind_q    <= CMD_SENSE_INT;
            head_q    <= 1'b0;
            unit_q    <= 2'h0;
            rdy_ref_q <= 1'b0;
            code_q    <= TERM_NORMAL;
        end else begin
            phase_q <= phase_d;
            code_q  <= code_d;
            // Capture head, unit and ready level at issue
            if (start_ok) begin
                kind_q    <= cmd_kind;
                head_q    <= cmd_head;
                unit_q    <= cmd_unit;
                rdy_ref_q <= drv_ready;
            end
        end
    end

    // Sticky flags, cleared by a new command
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            {seek_q, equip_q, nready_q, endcyl_q, crc_q} <= 5'h00;
            {ovr_q, nodata_q, nowrite_q, idmark_q, dmark_q} <= 5'h00;
        end else begin
            seek_q    <= upd(seek_q, set_seek, start_ok);
            equip_q   <= upd(equip_q, set_equip, start_ok);
            nready_q  <= upd(nready_q, issue_nr, start_ok);
            endcyl_q  <= upd(endcyl_q, set_endcyl, start_ok);
            crc_q     <= upd(crc_q, set_crc, start_ok);
            ovr_q     <= upd(ovr_q, set_ovr, start_ok);
            nodata_q  <= upd(nodata_q, set_nodata, start_ok);
            nowrite_q <= upd(nowrite_q, set_nowrite, start_ok);
            idmark_q  <= upd(idmark_q, set_idmark, start_ok);
            dmark_q   <= upd(dmark_q, set_dmark, start_ok);
        end
    end

    // Read port register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            res_data_q <= STATUS_RESET;
        end else if (res_rd) begin
            res_data_q <= (res_sel == RES_SEL_B) ? st_b : st_a;
        end
    end

    // ============================================================
    // Outputs
    assign res_data          = res_data_q;
    assign result_phase      = (phase_q == PH_RESULT);
    assign data_mark_missing = dmark_q;

    // ============================================================
    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_clean_start;
        start_ok && !cmd_invalid && !issue_nr;
    endsequence

    sequence s_exec_clear;
        exec && !crc_q && !ovr_q && !endcyl_q && !nodata_q && !idmark_q;
    endsequence

    a_nr_unready: assert property (issue_nr && !drv_ready
        |=> nready_q && code_q == TERM_FAILED && result_phase)
        else $error("Not-ready not reported");
    a_nr_one_side: assert property (start_ok && is_rw(cmd_kind) && !cmd_invalid
        && cmd_head && !drv_two_side |=> nready_q)
        else $error("Single-sided not-ready missing");
    a_code_invalid: assert property (start_ok && cmd_invalid
        |=> code_q == TERM_INVALID && result_phase)
        else $error("Invalid code not reported");
    a_code_rdy_chg: assert property (rdy_change |=> code_q == TERM_RDY_CHG)
        else $error("Ready change code missing");
    a_seek_flag: assert property (set_seek |=> seek_q && st_a[ST0_SEEK])
        else $error("Seek flag not set");
    a_recal_equip: assert property (recal_fail |=> equip_q && result_phase)
        else $error("Recalibrate failure not flagged");
    a_reserved_zero: assert property (res_rd ##1 1'b1 |->
        (res_data[ST1_RSVD_HI] == 1'b0 || $past(res_sel) == RES_SEL_A) &&
        (res_data[ST1_RSVD_LO] == 1'b0 || $past(res_sel) == RES_SEL_A))
        else $error("Reserved bits not zero");
    a_mark_pair: assert property ($rose(idmark_q) |-> dmark_q)
        else $error("Data-mark flag not paired");
    a_clear_start: assert property (s_clean_start |=> s_exec_clear)
        else $error("Flags not cleared at start");
    a_hold_result: assert property (result_phase && !cmd_start
        |=> $stable(st_a) && $stable(st_b))
        else $error("Result bytes moved before next command");
    a_read_back: assert property (res_rd && res_sel == RES_SEL_A
        |=> res_data[ST0_UNIT_HI:ST0_UNIT_LO] == $past(unit_q))
        else $error("Unit number not read back");

endmodule

// ---- sim/dcr_drive_model.sv ----
`timescale 1ns/1ps
// ============================================================
// Behavioural diskette drive: status levels and head position
module dcr_drive_model (
    // Clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rst,
    // Settings from the bench
    input  wire logic       cfg_ready,
    input  wire logic       cfg_fault,
    input  wire logic       cfg_wprot,
    input  wire logic       cfg_two_side,
    input  wire logic       cfg_pos_ld,
    input  wire logic [7:0] cfg_pos,
    // Step pulses toward cylinder zero
    input  wire logic       step,
    // Drive status lines
    output logic            drv_ready,
    output logic            drv_fault,
    output logic            drv_track0,
    output logic            drv_two_side,
    output logic            drv_wprot
);
    logic [7:0] pos_q;  // Current cylinder

    // Head moves one cylinder per step and stops at zero
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pos_q <= 8'h00;
        end else if (cfg_pos_ld) begin
            pos_q <= cfg_pos;
        end else if (step && pos_q != 8'h00) begin
            pos_q <= pos_q - 8'h01;
        end
    end

    // Track zero follows the head position, other status levels follow the bench settings
    assign drv_track0   = (pos_q == 8'h00);
    assign drv_ready    = cfg_ready;
    assign drv_fault    = cfg_fault;
    assign drv_wprot    = cfg_wprot;
    assign drv_two_side = cfg_two_side;
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
// ============================================================
// Result status bench
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module tb_top
    import dcr_pkg::*;
;
    logic       ref_clk, rst, cmd_start, cmd_invalid, cmd_head, res_rd, res_sel, drv_step;
    logic       ev_done, cfg_ready, cfg_fault, cfg_wprot, cfg_two_side, cfg_pos_ld;
    logic       result_phase, data_mark_missing, rdy, flt, tz, two, wp, hd, nr;
    logic [1:0] cmd_unit, un;
    logic [7:0] cfg_pos, res_data, a, b;
    logic [9:0] ev, m;       // Event pulses, seek_done first
    logic [16:0] e;          // Expected data mark, byte A, byte B
    dcr_cmd_t   cmd_kind, k;
    int         n_errors, compares, seed, t, r;

    dcr_drive_model drv_u (.ref_clk(ref_clk), .rst(rst), .cfg_ready(cfg_ready),
        .cfg_fault(cfg_fault), .cfg_wprot(cfg_wprot), .cfg_two_side(cfg_two_side),
        .cfg_pos_ld(cfg_pos_ld), .cfg_pos(cfg_pos), .step(drv_step), .drv_ready(rdy),
        .drv_fault(flt), .drv_track0(tz), .drv_two_side(two), .drv_wprot(wp));

    disk_ctrl_result_status dut_u (.ref_clk(ref_clk), .rst(rst), .cmd_start(cmd_start),
        .cmd_kind(cmd_kind), .cmd_invalid(cmd_invalid), .cmd_head(cmd_head),
        .cmd_unit(cmd_unit), .drv_ready(rdy), .drv_fault(flt), .drv_track0(tz),
        .drv_two_side(two), .drv_wprot(wp), .drv_step(drv_step), .ev_done(ev_done),
        .ev_seek_done(ev[0]), .ev_end_cyl(ev[1]), .ev_crc_id(ev[2]), .ev_crc_data(ev[3]),
        .ev_overrun(ev[4]), .ev_sector_miss(ev[5]), .ev_id_bad(ev[6]),
        .ev_start_miss(ev[7]), .ev_id_mark_miss(ev[8]), .ev_data_mark_miss(ev[9]),
        .res_rd(res_rd), .res_sel(res_sel), .res_data(res_data),
        .result_phase(result_phase), .data_mark_missing(data_mark_missing));

    // Expected {data mark, byte A, byte B} for one command
    function automatic logic [16:0] expect_res(input dcr_cmd_t c, input logic [9:0] v,
        input logic h, input logic [1:0] u, input logic n, input logic q, input logic p);
        logic [7:0] bb;
        logic       nd;
        logic       dm;
        nd = (v[5] && (c == CMD_READ_DATA || c == CMD_WRITE_DEL || c == CMD_SCAN))
            || (v[6] && c == CMD_READ_ID) || (v[7] && c == CMD_READ_CYL);
        bb = {v[1], 1'b0, v[2] | v[3], v[4], 1'b0, nd,
              p && (c == CMD_WRITE_DATA || c == CMD_WRITE_DEL || c == CMD_FORMAT), v[8]};
        dm = v[8] | v[9];
        if (n) begin
            expect_res = {1'b0, TERM_FAILED, 3'h1, h, u, 8'h00};
        end else begin
            expect_res = {dm, (q | (|bb) | dm) ? TERM_FAILED : TERM_NORMAL,
                          v[0] && c == CMD_SEEK, q, 1'b0, h, u, bb};
        end
    endfunction

    // Issue one command
    task automatic issue(input dcr_cmd_t c, input logic h, input logic [1:0] u, input logic i);
        @(posedge ref_clk);
        cmd_start   <= 1'b1;
        cmd_kind    <= c;
        cmd_head    <= h;
        cmd_unit    <= u;
        cmd_invalid <= i;
        @(posedge ref_clk);
        cmd_start   <= 1'b0;
        cmd_invalid <= 1'b0;
    endtask

    // One cycle of events and completion
    task automatic pulse_ev(input logic [9:0] v, input logic d);
        @(posedge ref_clk);
        ev      <= v;
        ev_done <= d;
        @(posedge ref_clk);
        ev      <= 10'h000;
        ev_done <= 1'b0;
    endtask

    // Step pulses with a gap between them
    task automatic steps(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            drv_step <= 1'b1;
            @(posedge ref_clk);
            drv_step <= 1'b0;
        end
    endtask

    // Read one result byte
    task automatic rd(input logic s, output logic [7:0] v);
        @(posedge ref_clk);
        res_rd  <= 1'b1;
        res_sel <= s;
        @(posedge ref_clk);
        res_rd  <= 1'b0;
        #1 v = res_data;
    endtask

    // Bounded wait for the result phase
    task automatic wait_res();
        for (int i = 0; i < 20; i++) begin
            @(posedge ref_clk);
            #1;
            if (result_phase === 1'b1) break;
        end
        `CHK(result_phase, 1'b1)
    endtask

    // Load the head position in the drive model
    task automatic load_pos(input logic [7:0] p);
        @(posedge ref_clk);
        cfg_pos    <= p;
        cfg_pos_ld <= 1'b1;
        @(posedge ref_clk);
        cfg_pos_ld <= 1'b0;
    endtask

    // Counts, verdict and end of run
    task automatic stop_test();
        $display("counts: %0d compares, %0d errors", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Clock of 40 ns
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        stop_test();
    end

    // Main sequence
    initial begin
        {rst, cfg_ready} = 2'b11;
        {cmd_start, cmd_invalid, cmd_head, res_rd, res_sel, drv_step, ev_done} = 7'h00;
        {cfg_fault, cfg_wprot, cfg_two_side, cfg_pos_ld} = 4'h1;
        {cmd_unit, cfg_pos, ev} = 20'h00000;
        cmd_kind = CMD_READ_DATA;
        n_errors = 0;
        compares = 0;
        seed = 32'hEE5A2301;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        #1 `CHK({res_data, result_phase, data_mark_missing}, {STATUS_RESET, 2'b00})
        issue(CMD_SPECIFY, 1'b0, 2'h0, 1'b1);
        wait_res();
        rd(RES_SEL_A, a);
        `CHK(a[7:6], TERM_INVALID)
        issue(CMD_READ_DATA, 1'b0, 2'h1, 1'b0);
        @(posedge ref_clk) cfg_ready <= 1'b0;
        wait_res();
        rd(RES_SEL_A, a);
        `CHK(a[7:6], TERM_RDY_CHG)
        @(posedge ref_clk) cfg_ready <= 1'b1;
        load_pos(8'h64);
        issue(CMD_RECAL, 1'b1, 2'h3, 1'b0);
        steps(76);
        @(posedge ref_clk) #1 `CHK(result_phase, 1'b0)
        steps(1);
        wait_res();
        rd(RES_SEL_A, a);
        `CHK(a, {TERM_FAILED, 3'h2, 3'h7})
        load_pos(8'h05);
        issue(CMD_RECAL, 1'b0, 2'h2, 1'b0);
        steps(5);
        // Command issued during execution must be ignored
        issue(CMD_READ_ID, 1'b1, 2'h1, 1'b1);
        pulse_ev(10'h000, 1'b1);
        wait_res();
        rd(RES_SEL_A, a);
        `CHK(a, {TERM_NORMAL, 4'h0, 2'h2})
        $display("test corners done");
        for (t = 0; t < 60; t++) begin
            r = $random(seed);
            k = dcr_cmd_t'((r[3:0] % 9 == 8) ? 4'h9 : 4'(r[3:0] % 9));
            {un, hd, m} = r[16:4];
            @(posedge ref_clk);
            cfg_ready    <= (r[19:17] != 3'h0);
            cfg_two_side <= r[20];
            cfg_wprot    <= r[21];
            cfg_fault    <= (r[24:22] == 3'h0);
            nr = (k <= CMD_SCAN) && (r[19:17] == 3'h0 || (hd && !r[20]));
            issue(k, hd, un, 1'b0);
            if (!nr) begin
                pulse_ev(m, 1'b0);
                pulse_ev(10'h000, 1'b1);
            end
            wait_res();
            e = expect_res(k, m, hd, un, nr, (r[24:22] == 3'h0), r[21]);
            rd(RES_SEL_A, a);
            rd(RES_SEL_B, b);
            `CHK(a, e[15:8])
            `CHK(b, e[7:0])
            `CHK(data_mark_missing, e[16])
            pulse_ev(~m, 1'b1);
            rd(RES_SEL_B, b);
            `CHK({data_mark_missing, b}, {e[16], e[7:0]})
        end
        $display("test random done");
        stop_test();
    end
endmodule
